// ===== rtl/dsou_consts.svh
`ifndef DSOU_CONSTS_SVH
`define DSOU_CONSTS_SVH
// Register port word addresses
`define DSOU_A_CTRL 6'h00
`define DSOU_A_CC 6'h01
`define DSOU_A_VAL1 6'h02
`define DSOU_A_VAL2 6'h03
`define DSOU_A_RES 6'h04
`define DSOU_A_DADR 6'h05
`define DSOU_A_GR 6'h08
`define DSOU_N_GR 6'h06
`define DSOU_A_IW 6'h10
`define DSOU_N_IW 6'h03
`define DSOU_A_MEM 6'h20
// Control word fields
`define DSOU_CTL_OP_HI 3
`define DSOU_CTL_INL 4
// Descriptor first word fields
`define DSOU_LEN_HI 4
`define DSOU_LEN_LO 0
`define DSOU_TYP_HI 14
`define DSOU_TYP_LO 12
`define DSOU_RSVD_MASK 16'h8fe0
// Type codes
`define DSOU_T_PKD_MIN 3'h6
`define DSOU_T_UZON 3'h1
`define DSOU_T_UPKD 3'h7
// Shift descriptor word fields
`define DSOU_SH_SIGN 7
`define DSOU_SH_CNT_HI 7
`define DSOU_SH_RND_HI 11
`define DSOU_SH_RND_LO 8
// Arithmetic limits
`define DSOU_MAX_P10 18
`define DSOU_INT_MAX 64'sh0000_0000_7fff_ffff
`define DSOU_INT_MIN 64'shffff_ffff_8000_0000
`endif

// ===== rtl/dsou_pkg.sv
package dsou_pkg;
  // Operation codes, in control word order
  typedef enum logic [3:0] {
    add_numeric_op, subtract_numeric_op, shift_numeric_op, compare_numeric_op,
    add_packed_op, subtract_packed_op, multiply_packed_op, divide_packed_op,
    shift_packed_op, compare_packed_op, numeric_to_integer_op, integer_to_numeric_op,
    packed_to_integer_op, integer_to_packed_op, numeric_to_packed_op, packed_to_numeric_op
  } dsou_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_EXEC} dsou_state_e;
  // Condition codes
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } dsou_cc_s;
  // Operand roles of one operation
  typedef struct packed {
    logic s0;
    logic s1;
    logic ii;
    logic io;
    logic sh;
    logic hd;
    logic [1:0] ds;
    logic p0;
    logic p1;
    logic pd;
  } dsou_role_s;
endpackage

// ===== rtl/dsou_unit.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dsou_consts.svh"
module dsou_unit #(
  parameter int MEM_WORDS = 16
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Register port
  input wire logic [5:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Status
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output dsou_pkg::dsou_cc_s CC_OUT
);
  import dsou_pkg::*;

  localparam int MW = $clog2(MEM_WORDS);

  // Operand memory must fit the 32-word window
  if (MEM_WORDS < 2 || MEM_WORDS > 32 || (1 << MW) != MEM_WORDS) begin : g_chk
    $error("MEM_WORDS must be a power of two from 2 to 32");
  end

  typedef struct packed {
    dsou_state_e st;
    dsou_op_e op;
    logic inl;
    logic [5:0][15:0] gr;
    logic [2:0][15:0] iw;
    logic [MEM_WORDS-1:0][15:0] mem;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] res;
    logic [31:0] iv;
    logic [15:0] dadr;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] wd;
    logic [15:0] sw;
    logic [15:0] ip;
    dsou_cc_s cc;
    logic bad;
    logic busy;
    logic done;
    logic [31:0] rd;
  } dsou_state_s;

  dsou_state_s s_reg, s_next;
  dsou_role_s ro;
  logic [2:0][31:0] pr;
  logic signed [63:0] a, b, r, t, m;
  logic [7:0] n8;
  logic [5:0] gi, ii, mi;
  logic dz, big, ov, ovi, uns;

  // Outputs come straight from the state register
  assign RDATA_OUT = s_reg.rd;
  assign BUSY_OUT = s_reg.busy;
  assign DONE_OUT = s_reg.done;
  assign CC_OUT = s_reg.cc;

  // Power of ten, capped at 10^18 so the power itself never wraps; a product with it still can
  function automatic logic signed [63:0] p10(input logic [7:0] n);
    logic signed [63:0] q;
    q = 64'sh1;
    for (int i = 0; i < `DSOU_MAX_P10; i++) begin
      if (i < n) q = q * 64'sha;
    end
    return q;
  endfunction

  // Reserved bits zero and type legal for the operand's class
  function automatic logic okd(input logic [15:0] w, input logic pk);
    logic [2:0] ty;
    ty = w[`DSOU_TYP_HI:`DSOU_TYP_LO];
    return ((w & `DSOU_RSVD_MASK) == 16'h0) &&
      (pk ? (ty >= `DSOU_T_PKD_MIN) : (ty < `DSOU_T_PKD_MIN));
  endfunction

  // Operand slots per operation: slot k is pair R2k/R2k+1 or in-line word k
  function automatic dsou_role_s role(input dsou_op_e op);
    dsou_role_s q;
    q = '0;
    case (op)
      add_numeric_op, subtract_numeric_op: begin
        q.s0 = 1'b1; q.s1 = 1'b1; q.hd = 1'b1; q.ds = 2'h2;
      end
      add_packed_op, subtract_packed_op, multiply_packed_op, divide_packed_op: begin
        q.s0 = 1'b1; q.s1 = 1'b1; q.hd = 1'b1; q.ds = 2'h2;
        q.p0 = 1'b1; q.p1 = 1'b1; q.pd = 1'b1;
      end
      shift_numeric_op, shift_packed_op: begin
        q.s0 = 1'b1; q.sh = 1'b1; q.hd = 1'b1; q.ds = 2'h1;
        q.p0 = (op == shift_packed_op); q.pd = (op == shift_packed_op);
      end
      compare_numeric_op, compare_packed_op: begin
        q.s0 = 1'b1; q.s1 = 1'b1;
        q.p0 = (op == compare_packed_op); q.p1 = (op == compare_packed_op);
      end
      numeric_to_integer_op, packed_to_integer_op: begin
        q.s0 = 1'b1; q.io = 1'b1; q.p0 = (op == packed_to_integer_op);
      end
      integer_to_numeric_op, integer_to_packed_op: begin
        q.ii = 1'b1; q.hd = 1'b1; q.ds = 2'h0; q.pd = (op == integer_to_packed_op);
      end
      numeric_to_packed_op, packed_to_numeric_op: begin
        q.s0 = 1'b1; q.hd = 1'b1; q.ds = 2'h1;
        q.p0 = (op == packed_to_numeric_op); q.pd = (op == numeric_to_packed_op);
      end
      default: q = '0;
    endcase
    return q;
  endfunction

  // Two-word operand per slot, from registers or through an in-line pointer
  for (genvar k = 0; k < 3; k++) begin : g_pair
    logic [MW-1:0] pa, pb;
    assign pa = s_reg.iw[k][MW-1:0];
    assign pb = pa + 1'b1;
    assign pr[k] = s_reg.inl ? {s_reg.mem[pb], s_reg.mem[pa]} :
      {s_reg.gr[2*k+1], s_reg.gr[2*k]};
  end

  // Next state: bus access, decode, execute
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rd = '0;
    ro = role(s_reg.op);
    gi = ADDR_IN - `DSOU_A_GR;
    ii = ADDR_IN - `DSOU_A_IW;
    mi = ADDR_IN - `DSOU_A_MEM;
    a = {{32{s_reg.v1[31]}}, s_reg.v1};
    b = {{32{s_reg.v2[31]}}, s_reg.v2};
    r = '0;
    t = '0;
    m = '0;
    dz = 1'b0;
    big = 1'b0;
    n8 = s_reg.sw[`DSOU_SH_SIGN] ? 8'(-s_reg.sw[`DSOU_SH_CNT_HI:0]) :
      s_reg.sw[`DSOU_SH_CNT_HI:0];
    uns = 1'b0;
    ov = 1'b0;
    ovi = 1'b0;
    // Reads never stall; unmapped words read zero
    if (RD_IN) begin
      if (ADDR_IN == `DSOU_A_CTRL) s_next.rd = {30'h0, s_reg.bad, s_reg.busy};
      else if (ADDR_IN == `DSOU_A_CC) s_next.rd = {28'h0, s_reg.cc};
      else if (ADDR_IN == `DSOU_A_VAL1) s_next.rd = s_reg.v1;
      else if (ADDR_IN == `DSOU_A_VAL2) s_next.rd = s_reg.v2;
      else if (ADDR_IN == `DSOU_A_RES) s_next.rd = s_reg.res;
      else if (ADDR_IN == `DSOU_A_DADR) s_next.rd = {16'h0, s_reg.dadr};
      else if (ADDR_IN >= `DSOU_A_GR && gi < `DSOU_N_GR) s_next.rd = {16'h0, s_reg.gr[gi[2:0]]};
      else if (ADDR_IN >= `DSOU_A_IW && ii < `DSOU_N_IW) s_next.rd = {16'h0, s_reg.iw[ii[1:0]]};
      else if (ADDR_IN >= `DSOU_A_MEM && mi < 6'(MEM_WORDS))
        s_next.rd = {16'h0, s_reg.mem[mi[MW-1:0]]};
    end
    case (s_reg.st)
      ST_IDLE: begin
        // Writes are ignored while an operation runs, so operands stay put
        if (WR_IN) begin
          if (ADDR_IN == `DSOU_A_CTRL) begin
            s_next.op = dsou_op_e'(WDATA_IN[`DSOU_CTL_OP_HI:0]);
            s_next.inl = WDATA_IN[`DSOU_CTL_INL];
            s_next.st = ST_DECODE;
            s_next.busy = 1'b1;
          end
          else if (ADDR_IN == `DSOU_A_VAL1) s_next.v1 = WDATA_IN;
          else if (ADDR_IN == `DSOU_A_VAL2) s_next.v2 = WDATA_IN;
          else if (ADDR_IN >= `DSOU_A_GR && gi < `DSOU_N_GR) s_next.gr[gi[2:0]] = WDATA_IN[15:0];
          else if (ADDR_IN >= `DSOU_A_IW && ii < `DSOU_N_IW) s_next.iw[ii[1:0]] = WDATA_IN[15:0];
          else if (ADDR_IN >= `DSOU_A_MEM && mi < 6'(MEM_WORDS))
            s_next.mem[mi[MW-1:0]] = WDATA_IN[15:0];
        end
      end
      ST_DECODE: begin
        // Gather and check every string descriptor before anything is stored; the shift word is gathered but not checked
        // Unused slots are fetched too but never judged, so stale words do no harm
        s_next.w0 = pr[0][15:0];
        s_next.w1 = pr[1][15:0];
        s_next.wd = pr[ro.ds][15:0];
        s_next.dadr = pr[ro.ds][31:16];
        s_next.iv = pr[1];
        s_next.ip = s_reg.iw[1];
        s_next.sw = s_reg.inl ? s_reg.iw[2] : s_reg.gr[4];
        s_next.bad = (ro.s0 && !okd(pr[0][15:0], ro.p0)) ||
          (ro.s1 && !okd(pr[1][15:0], ro.p1)) || (ro.hd && !okd(pr[ro.ds][15:0], ro.pd));
        s_next.st = ST_EXEC;
      end
      ST_EXEC: begin
        case (s_reg.op)
          add_numeric_op, add_packed_op: r = a + b;
          subtract_numeric_op, subtract_packed_op: r = b - a;
          multiply_packed_op: r = a * b;
          divide_packed_op: begin
            if (a == 64'sh0) dz = 1'b1;
            else r = b / a;
          end
          shift_numeric_op, shift_packed_op: begin
            if (!s_reg.sw[`DSOU_SH_SIGN]) begin
              if (n8 > 8'(`DSOU_MAX_P10)) begin
                r = a;
                big = (a != 64'sh0);
              end
              else r = a * p10(n8);
            end
            else if (n8 > 8'(`DSOU_MAX_P10)) r = '0;
            else begin
              m = (a < 0 ? -a : a) + 64'(s_reg.sw[`DSOU_SH_RND_HI:`DSOU_SH_RND_LO]) * p10(n8 - 8'h1);
              m = m / p10(n8);
              r = (a < 0) ? -m : m;
            end
          end
          integer_to_numeric_op, integer_to_packed_op: r = {{32{s_reg.iv[31]}}, s_reg.iv};
          default: r = a;
        endcase
        // Keep only the digits the destination can hold
        if (s_reg.wd[`DSOU_LEN_HI:`DSOU_LEN_LO] > 5'(`DSOU_MAX_P10)) t = r;
        else t = r % p10({3'h0, s_reg.wd[`DSOU_LEN_HI:`DSOU_LEN_LO]});
        uns = (s_reg.wd[`DSOU_TYP_HI:`DSOU_TYP_LO] == `DSOU_T_UZON) ||
          (s_reg.wd[`DSOU_TYP_HI:`DSOU_TYP_LO] == `DSOU_T_UPKD);
        ov = (t != r) || dz || big || (uns && r < 0);
        if (uns && t < 0) t = -t;
        ovi = (r > `DSOU_INT_MAX) || (r < `DSOU_INT_MIN);
        // An undefined case leaves results, codes and registers untouched
        if (!s_reg.bad) begin
          if (s_reg.op == compare_numeric_op || s_reg.op == compare_packed_op)
            s_next.cc = '{n: a < b, z: a == b, v: 1'b0, c: 1'b0};
          else if (ro.io) begin
            s_next.cc = '{n: r < 0, z: r == 0, v: ovi, c: ovi && r < 0};
            s_next.res = r[31:0];
          end
          else begin
            s_next.cc = '{n: t < 0, z: t == 0, v: ov, c: dz};
            s_next.res = t[31:0];
          end
          if (!s_reg.inl) begin
            if (ro.s0) s_next.gr[1:0] = '0;
            if (ro.s1) s_next.gr[3:2] = '0;
            if (ro.io) s_next.gr[3:2] = r[31:0];
          end
          else if (ro.io) begin
            s_next.mem[s_reg.ip[MW-1:0]] = r[15:0];
            s_next.mem[MW'(s_reg.ip[MW-1:0] + 1'b1)] = r[31:16];
          end
        end
        s_next.st = ST_IDLE;
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // State register; synchronous reset
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) s_reg <= '0;
    else s_reg <= s_next;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  // Fixed latency: two busy cycles then a done pulse
  run_timing_a: assert property (
    (s_reg.st == ST_IDLE && WR_IN && ADDR_IN == `DSOU_A_CTRL)
      |=> BUSY_OUT [*2] ##1 (DONE_OUT && !BUSY_OUT))
    else $error("operation latency wrong");
  nz_exclusive_a: assert property (!(CC_OUT.n && CC_OUT.z))
    else $error("N and Z both set");
  cmp_clears_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && s_reg.op == compare_packed_op)
      |=> !CC_OUT.v && !CC_OUT.c && (CC_OUT.z == (s_reg.v1 == s_reg.v2)))
    else $error("compare codes wrong");
  div_zero_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && s_reg.op == divide_packed_op && s_reg.v1 == 32'h0)
      |=> CC_OUT.c && CC_OUT.v)
    else $error("zero divisor not flagged");
  carry_clear_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && s_reg.op == add_numeric_op) |=> !CC_OUT.c)
    else $error("carry not cleared");
  inline_regs_a: assert property (
    (s_reg.st == ST_EXEC && s_reg.inl) |=> $stable(s_reg.gr))
    else $error("in-line form changed registers");
  src_clear_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.inl && !s_reg.bad && s_reg.op == add_packed_op)
      |=> s_reg.gr[1:0] == '0 && s_reg.gr[3:2] == '0 && $stable(s_reg.gr[5:4]))
    else $error("source registers not cleared");
  bad_no_store_a: assert property (
    (s_reg.st == ST_EXEC && s_reg.bad) |=> $stable(s_reg.res) && $stable(CC_OUT))
    else $error("undefined case stored a result");
  type_check_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && s_reg.op == add_numeric_op)
      |-> s_reg.w0[`DSOU_TYP_HI:`DSOU_TYP_LO] < `DSOU_T_PKD_MIN)
    else $error("reserved numeric type accepted");

  // Descriptor fetch: low word holds type and length, high word the address
  reg_fetch_a: assert property (
    (s_reg.st == ST_DECODE && !s_reg.inl && ro.hd)
      |=> s_reg.wd == s_reg.gr[{ro.ds, 1'b0}] && s_reg.dadr == s_reg.gr[{ro.ds, 1'b1}])
    else $error("register descriptor fetch wrong");
  inline_fetch_a: assert property (
    (s_reg.st == ST_DECODE && s_reg.inl && ro.hd)
      |=> s_reg.wd == s_reg.mem[s_reg.iw[ro.ds][MW-1:0]] &&
        s_reg.dadr == s_reg.mem[MW'(s_reg.iw[ro.ds][MW-1:0] + 1'b1)])
    else $error("pointer descriptor fetch wrong");
  shift_src_a: assert property (
    (s_reg.st == ST_DECODE && !s_reg.inl) |=> s_reg.sw == s_reg.gr[4])
    else $error("shift word not taken from R4");
  shift_inl_a: assert property (
    (s_reg.st == ST_DECODE && s_reg.inl) |=> s_reg.sw == s_reg.iw[2])
    else $error("in-line shift word not taken directly");

  // Stored strings and integers, and the numeric compare: flag rules
  zero_store_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && ro.hd) |=> !CC_OUT.z || s_reg.res == 32'h0)
    else $error("zero flag without a zero result");
  carry_other_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && ro.hd && s_reg.op != divide_packed_op)
      |=> !CC_OUT.c)
    else $error("carry set outside divide");
  uns_neg_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && ro.hd && uns && r < 0)
      |=> CC_OUT.v && !CC_OUT.n)
    else $error("negative result kept in unsigned string");
  cmp_numeric_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && s_reg.op == compare_numeric_op)
      |=> CC_OUT.n == ($signed(s_reg.v1) < $signed(s_reg.v2)) && !CC_OUT.v && !CC_OUT.c)
    else $error("numeric compare codes wrong");
  int_flags_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && ro.io)
      |=> CC_OUT.v || (CC_OUT.n == s_reg.res[31] && CC_OUT.z == (s_reg.res == 32'h0)))
    else $error("integer result codes wrong");
  int_carry_a: assert property (
    (s_reg.st == ST_EXEC && !s_reg.bad && ro.io) |=> !CC_OUT.c || CC_OUT.v)
    else $error("borrow without overflow");

  // Undefined cases touch no register or memory word
  bad_regs_a: assert property (
    (s_reg.st == ST_EXEC && s_reg.bad) |=> $stable(s_reg.gr) && $stable(s_reg.mem))
    else $error("undefined case changed storage");
  done_pulse_a: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");

  // Main scenarios
  add_done_c: cover property (s_reg.st == ST_EXEC && s_reg.op == add_packed_op ##1 DONE_OUT);
  div_zero_c: cover property (DONE_OUT && CC_OUT.c);
  bad_desc_c: cover property (DONE_OUT && s_reg.bad);
  inline_c: cover property (s_reg.st == ST_EXEC && s_reg.inl && !s_reg.bad);
  shift_right_c: cover property (s_reg.st == ST_EXEC && s_reg.sw[`DSOU_SH_SIGN]);
endmodule
`default_nettype wire

// ===== tb/dsou_host.sv
`timescale 1ns/1ns
`default_nettype none
module dsou_host (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [5:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [31:0] rdata_in
);
  // Idle bus from time zero
  initial begin
    addr_out = 6'h00;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write; data inverted once released so stale values never pass
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ===== tb/decimal_string_operand_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dsou_consts.svh"
module decimal_string_operand_unit_tb;
  import dsou_pkg::*;
  typedef logic [31:0] dsou_w6_t [6];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic busy;
  logic done;
  dsou_cc_s cc;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  dsou_unit #(.MEM_WORDS(16)) DUT (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BUSY_OUT(busy),
    .DONE_OUT(done), .CC_OUT(cc));
  dsou_host host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));
  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  // Descriptor first word: type in 14..12, digit count in 4..0
  function automatic logic [31:0] dsc(input logic [2:0] t, input logic [4:0] n);
    return {17'h0, t, 7'h0, n};
  endfunction
  task automatic setup(input dsou_w6_t r, input logic [31:0] v1, input logic [31:0] v2);
    for (int i = 0; i < 6; i++) begin
      host.wr(`DSOU_A_GR + 6'(i), r[i]);
    end
    host.wr(`DSOU_A_VAL1, v1);
    host.wr(`DSOU_A_VAL2, v2);
  endtask
  // Start an operation; done follows the take edge by exactly two edges
  task automatic run(input dsou_op_e op, input logic inl, input logic [3:0] ecc);
    host.wr(`DSOU_A_CTRL, {27'h0, inl, op});
    #1;
    chk({31'h0, busy}, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({30'h0, busy, done}, 32'h1);
    chk({28'h0, cc}, {28'h0, ecc});
  endtask
  // Register form op, five-digit operands; compares leave the result unchecked
  task automatic op3(input dsou_op_e op, input logic [2:0] t0, input logic [2:0] t1,
    input logic [31:0] r4, input logic [31:0] v1, input logic [31:0] v2,
    input logic [3:0] ecc, input logic [31:0] eres);
    setup('{dsc(t0, 5'h5), 32'h0100, dsc(t1, 5'h5), 32'h0200, r4, 32'h1234}, v1, v2);
    run(op, 1'b0, ecc);
    if (op != compare_numeric_op && op != compare_packed_op) begin
      rdc(`DSOU_A_RES, eres);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(`DSOU_A_CC, 32'h0);
    op3(add_numeric_op, 3'h0, 3'h3, dsc(3'h4, 5'h5), 32'h7, 32'h3, 4'h0, 32'ha);
    rdc(`DSOU_A_DADR, 32'h1234);
    for (int i = 0; i < 4; i++) rdc(`DSOU_A_GR + 6'(i), 32'h0);
    rdc(`DSOU_A_GR + 6'h4, dsc(3'h4, 5'h5));
    op3(subtract_numeric_op, 3'h2, 3'h5, dsc(3'h1, 5'h5), 32'h9, 32'h4, 4'h2, 32'h5);
    op3(add_packed_op, 3'h6, 3'h7, dsc(3'h6, 5'h5), 32'h1869f, 32'h1, 4'h6, 32'h0);
    op3(subtract_packed_op, 3'h6, 3'h6, dsc(3'h6, 5'h5), 32'h8, 32'h3, 4'h8, -32'sh5);
    op3(multiply_packed_op, 3'h6, 3'h7, dsc(3'h6, 5'h5), 32'hc, -32'sh3, 4'h8, -32'sh24);
    op3(divide_packed_op, 3'h6, 3'h6, dsc(3'h6, 5'h5), 32'h4, -32'sh9, 4'h8, -32'sh2);
    op3(divide_packed_op, 3'h7, 3'h6, dsc(3'h6, 5'h5), 32'h0, 32'h4d, 4'h7, 32'h0);
    op3(compare_numeric_op, 3'h0, 3'h4, 32'h0, -32'sh5, 32'h3, 4'h8, 32'h0);
    op3(compare_packed_op, 3'h6, 3'h7, 32'h0, 32'h5, 32'h5, 4'h4, 32'h0);
    op3(compare_packed_op, 3'h6, 3'h6, 32'h0, 32'h7, 32'h2, 4'h0, 32'h0);
    op3(shift_packed_op, 3'h6, 3'h6, 32'h5ff, 32'h7b, 32'h0, 4'h0, 32'hc);
    rdc(`DSOU_A_GR + 6'h4, 32'h5ff);
    op3(shift_numeric_op, 3'h1, 3'h0, 32'h0, -32'sh2d, 32'h0, 4'h8, -32'sh2d);
    op3(shift_numeric_op, 3'h3, 3'h2, 32'h2, 32'h7, 32'h0, 4'h0, 32'h2bc);
    op3(numeric_to_packed_op, 3'h0, 3'h6, 32'h0, -32'sh2d, 32'h0, 4'h8, -32'sh2d);
    op3(packed_to_numeric_op, 3'h7, 3'h4, 32'h0, 32'h1e, 32'h0, 4'h0, 32'h1e);
    rdc(`DSOU_A_CTRL, 32'h0);
    // Integer conversions in register form
    setup('{dsc(3'h0, 5'h5), 32'h0100, 32'h0, 32'h0, 32'h0, 32'h0}, -32'sh7, 32'h0);
    run(numeric_to_integer_op, 1'b0, 4'h8);
    rdc(`DSOU_A_GR + 6'h2, 32'hfff9);
    rdc(`DSOU_A_GR + 6'h3, 32'hffff);
    setup('{dsc(3'h0, 5'h2), 32'h0300, 32'h7b, 32'h0, 32'h0, 32'h0}, 32'h0, 32'h0);
    run(integer_to_numeric_op, 1'b0, 4'h2);
    rdc(`DSOU_A_RES, 32'h17);
    setup('{dsc(3'h7, 5'h5), 32'h0300, 32'hfffe, 32'hffff, 32'h0, 32'h0}, 32'h0, 32'h0);
    run(integer_to_packed_op, 1'b0, 4'h2);
    rdc(`DSOU_A_RES, 32'h2);
    // Reserved types and reserved bits: only the bad flag and DADR change
    op3(add_packed_op, 3'h5, 3'h6, dsc(3'h6, 5'h5), 32'h1, 32'h1, 4'h2, 32'h2);
    rdc(`DSOU_A_CTRL, 32'h2);
    op3(add_numeric_op, 3'h0, 3'h7, dsc(3'h0, 5'h5), 32'h1, 32'h1, 4'h2, 32'h2);
    rdc(`DSOU_A_CTRL, 32'h2);
    setup('{32'h8006, 32'h0100, dsc(3'h6, 5'h5), 32'h0, dsc(3'h6, 5'h5), 32'h0}, 32'h1, 32'h1);
    run(add_packed_op, 1'b0, 4'h2);
    rdc(`DSOU_A_GR, 32'h8006);
    // In-line form: pointers into memory, registers untouched
    for (int i = 0; i < 6; i++) begin
      host.wr(`DSOU_A_MEM + 6'(i), (i % 2 == 0) ? dsc(3'(6 + (i / 2) % 2), 5'h5) : 32'h700);
    end
    host.wr(`DSOU_A_IW, 32'h0);
    host.wr(`DSOU_A_IW + 6'h1, 32'h2);
    host.wr(`DSOU_A_IW + 6'h2, 32'h4);
    host.wr(`DSOU_A_VAL1, 32'h1);
    host.wr(`DSOU_A_VAL2, 32'h2);
    run(add_packed_op, 1'b1, 4'h0);
    rdc(`DSOU_A_RES, 32'h3);
    rdc(`DSOU_A_DADR, 32'h700);
    host.wr(`DSOU_A_IW + 6'h1, 32'h8);
    host.wr(`DSOU_A_VAL1, 32'h12345);
    run(packed_to_integer_op, 1'b1, 4'h0);
    rdc(`DSOU_A_MEM + 6'h8, 32'h2345);
    rdc(`DSOU_A_MEM + 6'h9, 32'h1);
    rdc(`DSOU_A_GR, 32'h8006);
    rdc(`DSOU_A_GR + 6'h2, dsc(3'h6, 5'h5));
    complete_run();
  end
endmodule
`default_nettype wire
